//--- gpio_bridge_params.svh
// Constants of the pin bridge: codes, phase points and timing counts
`ifndef GPIO_BRIDGE_PARAMS_SVH
`define GPIO_BRIDGE_PARAMS_SVH

`define PROTO_BIT         3
`define SLOT_W            16
`define BUF_W             48
`define BUF_ONES          48'hffff_ffff_ffff
`define LAST_SLOT         2'h2

`define PH_START_LO       5'h01
`define PH_DATA_FIRST     5'h03
`define PH_DATA_LAST      5'h12
`define PH_SAMPLE_FIRST   5'h05
`define PH_SAMPLE_LAST    5'h13
`define PH_ACK_LO         5'h13
`define PH_ACK_HI         5'h14
`define PH_ACK_SAMPLE     5'h15
`define PH_FIN_HI         5'h16
`define PH_LAST           5'h17

`define I2C_INI_START     4'h6
`define I2C_INI_STOP      4'h1
`define I2C_INI_BLANK     4'h0
`define I2C_INI_NOTX      4'h7
`define I2C_FIN_ACK       4'h0
`define I2C_FIN_NACK      4'h8
`define I2C_FIN_NACK_STOP 4'h9
`define I2C_RD_BLANK_HI   4'h7
`define I2C_RD_SLV_ACK    4'h7
`define I2C_RD_SLV_NACK   4'hf
`define I2C_RD_ACK_STOP   4'h1
`define I2C_RD_NACK_STOP  4'h9

`define SPI_INI_LOW       4'h8
`define SPI_INI_FALL      4'ha
`define SPI_INI_HIGH      4'h9
`define SPI_INI_NOTX      4'hf
`define SPI_FIN_HIGH      4'h9
`define SPI_RD_INI        4'h7
`define SPI_RD_FIN        4'hf

`define CLK_HZ            10000000
`define WDOG_SEC          2
`define WDOG_CYCLES       (`WDOG_SEC * `CLK_HZ)

`endif

//--- gpio_bridge_pkg.sv
// Types shared by the pin bridge modules
`default_nettype none
package gpio_bridge_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN  = 2'h1
	} bridge_state_t;
	typedef logic [3:0] nibble_t;
	typedef logic [4:0] phase_t;
endpackage : gpio_bridge_pkg
`default_nettype wire

//--- i2c_slot_wave.sv
// Line levels of one I2C slot for a given phase (1 = released)
`include "gpio_bridge_params.svh"
`default_nettype none
module i2c_slot_wave (
	input  wire gpio_bridge_pkg::phase_t  phase,
	input  wire gpio_bridge_pkg::nibble_t initial_control_nibble,
	input  wire gpio_bridge_pkg::nibble_t final_control_nibble,
	input  wire logic                     tx_bit,
	input  wire logic                     prev_sda,
	output logic                          sda_lvl,
	output logic                          scl_lvl
);
	logic ack_lvl;
	always_comb begin
		ack_lvl = (final_control_nibble != `I2C_FIN_ACK);
		sda_lvl = 1'b1;
		scl_lvl = 1'b1;
		case (initial_control_nibble)
			`I2C_INI_NOTX: begin
				sda_lvl = 1'b1;
				scl_lvl = 1'b1;
			end
			`I2C_INI_STOP: begin
				sda_lvl = (phase > `PH_START_LO);
				scl_lvl = (phase != 5'h00);
			end
			default: begin
				if (phase <= 5'h02) begin
					if (initial_control_nibble == `I2C_INI_START) begin
						sda_lvl = (phase == 5'h00);
						scl_lvl = (phase != 5'h02);
					end else begin
						sda_lvl = prev_sda;
						scl_lvl = 1'b0;
					end
				end else if (phase <= `PH_DATA_LAST) begin
					// Clock is high on even phases, so a data change never meets a rise
					sda_lvl = tx_bit;
					scl_lvl = !phase[0];
				end else if (phase <= `PH_ACK_HI) begin
					sda_lvl = ack_lvl;
					scl_lvl = (phase == `PH_ACK_HI);
				end else if (final_control_nibble == `I2C_FIN_NACK_STOP) begin
					sda_lvl = (phase == `PH_LAST);
					scl_lvl = (phase != `PH_ACK_SAMPLE);
				end else begin
					// Ack level kept, so after an ACK final code the line sits low between bytes
					sda_lvl = ack_lvl;
					scl_lvl = 1'b0;
				end
			end
		endcase
	end
endmodule : i2c_slot_wave
`default_nettype wire

//--- spi_slot_wave.sv
// Line levels of one mode 3 SPI slot for a given phase (1 = released)
`include "gpio_bridge_params.svh"
`default_nettype none
module spi_slot_wave (
	input  wire gpio_bridge_pkg::phase_t  phase,
	input  wire gpio_bridge_pkg::nibble_t initial_control_nibble,
	input  wire gpio_bridge_pkg::nibble_t final_control_nibble,
	input  wire logic                     tx_bit,
	output logic                          cs_lvl,
	output logic                          sd_lvl,
	output logic                          sck_lvl
);
	logic in_data;
	always_comb begin
		in_data = (phase >= `PH_DATA_FIRST) && (phase <= `PH_DATA_LAST);
		cs_lvl  = 1'b1;
		sd_lvl  = 1'b1;
		sck_lvl = 1'b1;
		if (initial_control_nibble != `SPI_INI_NOTX &&
			initial_control_nibble != `SPI_INI_HIGH) begin
			if (phase == 5'h00) begin
				cs_lvl = (initial_control_nibble == `SPI_INI_FALL);
			end else if (phase >= `PH_ACK_SAMPLE) begin
				cs_lvl = (final_control_nibble == `SPI_FIN_HIGH);
			end else begin
				cs_lvl = 1'b0;
			end
			// Data moves on the fall and stands set up for the rise
			sck_lvl = in_data ? !phase[0] : 1'b1;
			sd_lvl  = in_data ? tx_bit : 1'b1;
		end
	end
endmodule : spi_slot_wave
`default_nettype wire

//--- gpio_bridge.sv
// Command driven I2C or SPI master on three general purpose pins
// Operation
// - I2C start code: start condition, then byte
// - I2C stop code: stop, lines high, skip
// - I2C no-transmit: release lines, skip word
// - Final code selects ACK, NACK, NACK plus stop
// - SPI initial code sets select low/fall/high
// - SPI no-transmit releases port, skips word
// - SPI select high releases lines, skips word
// - SPI final X000 keeps select low, 1001 raises
// - Write loads buffer; bad code fills ones
// - Start shifts three bytes, stores received bytes
// - Pin 4 data, pin 5 clock, pin 3 select
// - Read returns the whole six byte buffer
// - I2C initial nibble rewritten with status code
// - I2C final nibble rewritten with ack status
// - SPI status reads 0111 and 1111
// - Lines hold between commands; watchdog restores
// - Initial nibble bit 3 picks SPI or I2C
// - Three packed slots: nibble, byte, nibble
// - SPI master runs in mode 3
// - Each line phase lasts one host clock
`include "gpio_bridge_params.svh"
`default_nettype none
module gpio_bridge #(
	parameter int unsigned WDOG_CYCLES = `WDOG_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                nrst,
	input  wire logic                buffer_write_command,
	input  wire logic [`BUF_W-1:0]   write_data,
	input  wire logic                write_pec_ok,
	input  wire logic                start_transfer_command,
	input  wire logic                host_tick,
	input  wire logic                host_chip_select_rise,
	input  wire logic                buffer_read_command,
	output logic      [`BUF_W-1:0]   read_data,
	output logic                     read_valid,
	output logic                     busy,
	input  wire logic                gpio3_in,
	output logic                     gpio3_out,
	output logic                     gpio3_oe,
	input  wire logic                gpio4_in,
	output logic                     gpio4_out,
	output logic                     gpio4_oe,
	input  wire logic                gpio5_in,
	output logic                     gpio5_out,
	output logic                     gpio5_oe
);
	localparam int CNT_W = $clog2(WDOG_CYCLES + 1);

	generate
		if (WDOG_CYCLES < 2) begin : g_bad_wdog
			$error("WDOG_CYCLES must be at least 2");
		end
	endgenerate

	function automatic logic [`SLOT_W-1:0] slot_word(input logic [`BUF_W-1:0] b,
		input logic [1:0] s);
		case (s)
			2'h0:    slot_word = b[47:32];
			2'h1:    slot_word = b[31:16];
			default: slot_word = b[15:0];
		endcase
	endfunction : slot_word

	function automatic logic [`BUF_W-1:0] put_slot(input logic [`BUF_W-1:0] b,
		input logic [1:0] s, input logic [`SLOT_W-1:0] w);
		logic [`BUF_W-1:0] r;
		r = b;
		case (s)
			2'h0:    r[47:32] = w;
			2'h1:    r[31:16] = w;
			default: r[15:0] = w;
		endcase
		put_slot = r;
	endfunction : put_slot

	gpio_bridge_pkg::bridge_state_t state_ff, nxt_state;
	logic [1:0]                     slot_ff, nxt_slot;
	gpio_bridge_pkg::phase_t        phase_ff, nxt_phase;
	logic [`BUF_W-1:0]              buf_ff, nxt_buf;
	logic                           bad_pec_ff, nxt_bad_pec;
	logic [7:0]                     rx_ff, nxt_rx;
	logic                           ack_ff, nxt_ack;
	logic                           blank_hi_ff, nxt_blank_hi;
	logic                           cs_lvl_ff, nxt_cs_lvl;
	logic                           sd_lvl_ff, nxt_sd_lvl;
	logic                           sck_lvl_ff, nxt_sck_lvl;
	logic [CNT_W-1:0]               wd_cnt_ff, nxt_wd_cnt;
	logic [`BUF_W-1:0]              rd_data_ff, nxt_rd_data;
	logic                           rd_valid_ff, nxt_rd_valid;

	logic [`SLOT_W-1:0]      cur_word;
	gpio_bridge_pkg::nibble_t cur_ini, cur_fin;
	logic [7:0]              cur_data;
	logic                    is_spi;
	logic [4:0]              bit_off;
	logic                    tx_bit;
	logic                    i2c_sda, i2c_scl;
	logic                    spi_cs, spi_sd, spi_sck;
	logic                    skipped;
	gpio_bridge_pkg::nibble_t st_ini, st_fin;
	logic                    wd_expired;

	assign cur_word = slot_word(buf_ff, slot_ff);
	assign cur_ini  = cur_word[15:12];
	assign cur_data = cur_word[11:4];
	assign cur_fin  = cur_word[3:0];
	assign is_spi   = cur_ini[`PROTO_BIT];
	assign bit_off  = phase_ff - `PH_DATA_FIRST;
	assign tx_bit   = cur_data[3'h7 - bit_off[3:1]]; // MSB goes first

	i2c_slot_wave u_i2c (
		.phase                  (phase_ff),
		.initial_control_nibble (cur_ini),
		.final_control_nibble   (cur_fin),
		.tx_bit                 (tx_bit),
		.prev_sda               (sd_lvl_ff),
		.sda_lvl                (i2c_sda),
		.scl_lvl                (i2c_scl)
	);

	spi_slot_wave u_spi (
		.phase                  (phase_ff),
		.initial_control_nibble (cur_ini),
		.final_control_nibble   (cur_fin),
		.tx_bit                 (tx_bit),
		.cs_lvl                 (spi_cs),
		.sd_lvl                 (spi_sd),
		.sck_lvl                (spi_sck)
	);

	// Status written back into the slot at its last phase
	always_comb begin
		st_ini  = cur_ini;
		st_fin  = cur_fin;
		skipped = 1'b0;
		if (is_spi) begin
			st_ini  = `SPI_RD_INI;
			st_fin  = `SPI_RD_FIN;
			skipped = (cur_ini == `SPI_INI_NOTX) || (cur_ini == `SPI_INI_HIGH);
		end else begin
			skipped = (cur_ini == `I2C_INI_STOP) || (cur_ini == `I2C_INI_NOTX);
			if (cur_ini == `I2C_INI_BLANK && blank_hi_ff) begin
				st_ini = `I2C_RD_BLANK_HI;
			end
			if (!skipped) begin
				case (cur_fin)
					`I2C_FIN_NACK:      st_fin = ack_ff ? `I2C_RD_SLV_ACK : `I2C_RD_SLV_NACK;
					`I2C_FIN_NACK_STOP: st_fin = ack_ff ? `I2C_RD_ACK_STOP : `I2C_RD_NACK_STOP;
					default:            st_fin = cur_fin;
				endcase
			end
		end
	end

	assign wd_expired = (wd_cnt_ff == CNT_W'(WDOG_CYCLES - 1));

	always_comb begin
		nxt_state    = state_ff;
		nxt_slot     = slot_ff;
		nxt_phase    = phase_ff;
		nxt_buf      = buf_ff;
		nxt_bad_pec  = bad_pec_ff;
		nxt_rx       = rx_ff;
		nxt_ack      = ack_ff;
		nxt_blank_hi = blank_hi_ff;
		nxt_cs_lvl   = cs_lvl_ff;
		nxt_sd_lvl   = sd_lvl_ff;
		nxt_sck_lvl  = sck_lvl_ff;
		nxt_wd_cnt   = wd_cnt_ff;
		nxt_rd_data  = rd_data_ff;
		nxt_rd_valid = 1'b0;
		case (state_ff)
			gpio_bridge_pkg::ST_IDLE: begin
				if (buffer_write_command) begin
					nxt_bad_pec = !write_pec_ok;
					if (write_pec_ok) begin
						nxt_buf = write_data;
					end
				end
				if (host_chip_select_rise && bad_pec_ff) begin
					nxt_buf     = `BUF_ONES;
					nxt_bad_pec = buffer_write_command && !write_pec_ok; // New bad code wins
				end
				if (buffer_read_command) begin
					nxt_rd_data  = buf_ff;
					nxt_rd_valid = 1'b1;
				end
				// Lines hold their levels until the watchdog runs out
				if (!wd_expired) begin
					nxt_wd_cnt = wd_cnt_ff + CNT_W'(1);
				end else begin
					nxt_cs_lvl  = 1'b1;
					nxt_sd_lvl  = 1'b1;
					nxt_sck_lvl = 1'b1;
				end
				if (start_transfer_command) begin
					nxt_state  = gpio_bridge_pkg::ST_RUN;
					nxt_slot   = 2'h0;
					nxt_phase  = 5'h00;
					nxt_wd_cnt = '0;
				end
			end
			gpio_bridge_pkg::ST_RUN: begin
				nxt_wd_cnt = '0;
				if (host_chip_select_rise) begin
					// A frame cut short leaves the lines where they stand
					nxt_state = gpio_bridge_pkg::ST_IDLE;
				end else if (host_tick) begin
					if (is_spi) begin
						nxt_cs_lvl  = spi_cs;
						nxt_sd_lvl  = spi_sd;
						nxt_sck_lvl = spi_sck;
					end else begin
						nxt_sd_lvl  = i2c_sda;
						nxt_sck_lvl = i2c_scl;
					end
					// Pins show last phase's levels, so sample one phase late
					if (phase_ff == 5'h00) begin
						nxt_blank_hi = gpio4_in;
					end
					if (phase_ff >= `PH_SAMPLE_FIRST && phase_ff <= `PH_SAMPLE_LAST &&
						phase_ff[0]) begin
						nxt_rx = {rx_ff[6:0], gpio4_in};
					end
					if (phase_ff == `PH_ACK_SAMPLE) begin
						nxt_ack = !gpio4_in;
					end
					if (phase_ff == `PH_LAST) begin
						nxt_buf = put_slot(buf_ff, slot_ff,
							{st_ini, skipped ? cur_data : rx_ff, st_fin});
						nxt_phase = 5'h00;
						if (slot_ff == `LAST_SLOT) begin
							nxt_state = gpio_bridge_pkg::ST_IDLE;
						end else begin
							nxt_slot = slot_ff + 2'h1;
						end
					end else begin
						nxt_phase = phase_ff + 5'h01;
					end
				end
			end
			default: begin
				nxt_state = gpio_bridge_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff    <= gpio_bridge_pkg::ST_IDLE;
			slot_ff     <= 2'h0;
			phase_ff    <= 5'h00;
			buf_ff      <= `BUF_ONES;
			bad_pec_ff  <= 1'b0;
			rx_ff       <= 8'h00;
			ack_ff      <= 1'b0;
			blank_hi_ff <= 1'b0;
			cs_lvl_ff   <= 1'b1;
			sd_lvl_ff   <= 1'b1;
			sck_lvl_ff  <= 1'b1;
			wd_cnt_ff   <= '0;
			rd_data_ff  <= '0;
			rd_valid_ff <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			slot_ff     <= nxt_slot;
			phase_ff    <= nxt_phase;
			buf_ff      <= nxt_buf;
			bad_pec_ff  <= nxt_bad_pec;
			rx_ff       <= nxt_rx;
			ack_ff      <= nxt_ack;
			blank_hi_ff <= nxt_blank_hi;
			cs_lvl_ff   <= nxt_cs_lvl;
			sd_lvl_ff   <= nxt_sd_lvl;
			sck_lvl_ff  <= nxt_sck_lvl;
			wd_cnt_ff   <= nxt_wd_cnt;
			rd_data_ff  <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	// Open drain: the pad only ever pulls low, a high comes from pull-ups
	assign gpio3_out  = 1'b0;
	assign gpio4_out  = 1'b0;
	assign gpio5_out  = 1'b0;
	assign gpio3_oe   = !cs_lvl_ff;
	assign gpio4_oe   = !sd_lvl_ff;
	assign gpio5_oe   = !sck_lvl_ff;
	assign read_data  = rd_data_ff;
	assign read_valid = rd_valid_ff;
	assign busy       = (state_ff == gpio_bridge_pkg::ST_RUN);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_tick_at(logic [4:0] p);
		busy && host_tick && !host_chip_select_rise && phase_ff == p;
	endsequence

	a_bad_pec_fill: assert property (!busy && bad_pec_ff && host_chip_select_rise
		|=> buf_ff == `BUF_ONES) else $error("buffer not filled with ones");
	a_read_returns: assert property (!busy && buffer_read_command
		|=> read_valid && read_data == $past(buf_ff)) else $error("read data wrong");
	a_start_runs: assert property (!busy && start_transfer_command
		|=> busy && slot_ff == 2'h0 && phase_ff == 5'h00) else $error("no run");
	a_phase_per_tick: assert property (busy && !host_tick && !host_chip_select_rise
		|=> $stable(phase_ff) && $stable(gpio5_oe)) else $error("phase moved");
	a_i2c_start_seq: assert property (s_tick_at(`PH_START_LO) && !is_spi &&
		cur_ini == `I2C_INI_START |=> gpio4_oe && !gpio5_oe) else $error("no start");
	a_i2c_nack_stop: assert property (s_tick_at(`PH_LAST) && !is_spi &&
		cur_ini == `I2C_INI_BLANK && cur_fin == `I2C_FIN_NACK_STOP
		|=> !gpio4_oe && !gpio5_oe) else $error("no stop after nack");
	a_i2c_pin3_free: assert property (busy && host_tick && !is_spi
		|=> $stable(gpio3_oe)) else $error("pin 3 moved in I2C");
	a_spi_notx_free: assert property (s_tick_at(5'h00) && is_spi &&
		cur_ini == `SPI_INI_NOTX |=> !gpio3_oe && !gpio4_oe && !gpio5_oe)
		else $error("port not released");
	a_spi_status: assert property (s_tick_at(`PH_LAST) && is_spi
		|=> slot_word(buf_ff, $past(slot_ff)) ==? 16'h7??f) else $error("bad status");
	a_wdog_release: assert property (!busy && wd_expired && !start_transfer_command
		|=> !gpio3_oe && !gpio4_oe && !gpio5_oe) else $error("watchdog no release");
	a_idle_hold: assert property (!busy && !wd_expired
		|=> $stable(gpio3_oe) && $stable(gpio4_oe) && $stable(gpio5_oe))
		else $error("lines moved while idle");
endmodule : gpio_bridge
`default_nettype wire

//--- slave_model.sv
// Behavioural I2C and mode 3 SPI slave hanging on the three pin lines
`default_nettype none
module slave_model (
	input  wire logic        spi_mode,
	input  wire logic        ack_en,
	input  wire logic [23:0] spi_bytes,
	input  wire logic        cs_line,
	input  wire logic        sd_line,
	input  wire logic        sck_line,
	output logic             sd_pull
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] shreg;
	int         idx;
	int         cnt;
	initial begin
		sd_pull = 1'b0;
		shreg = 8'h00;
		idx = 0;
		cnt = 0;
	end
	// Each select fall loads the next byte, so a held-low select sends only one
	always @(negedge cs_line) if (spi_mode) begin
		shreg = spi_bytes[23 - 8 * idx -: 8];
		idx = (idx + 1) % 3;
		cnt = 0;
	end
	always @(posedge cs_line) if (spi_mode) begin
		sd_pull = 1'b0;
	end
	// Mode 3: shift out on the falling clock, the master samples on the rise
	always @(negedge sck_line) begin
		if (spi_mode && !cs_line) begin
			sd_pull = (cnt < 8) ? !shreg[7] : 1'b0;
			shreg = shreg << 1;
			cnt = cnt + 1;
		end else if (!spi_mode) begin
			sd_pull = (cnt == 8) && ack_en;
			if (cnt >= 9) cnt = 0;
		end
	end
	always @(posedge sck_line) if (!spi_mode) begin
		cnt = cnt + 1;
	end
	// Start condition restarts the bit count
	always @(negedge sd_line) if (!spi_mode && sck_line) begin
		cnt = 0;
	end
endmodule : slave_model
`default_nettype wire

//--- gpio_bridge_tb_top.sv
// Self-checking bench for the pin bridge with a buffer model and a slave model
`default_nettype none
module gpio_bridge_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WD = 50;
	logic        clk, nrst, wr_cmd, pec_ok, st_cmd, tick, cs_rise, rd_cmd;
	logic        rd_valid, busy, oe3, oe4, oe5, l3, l4, l5, sd_pull, spi_mode, ack_en, cs_hi;
	logic [47:0] wr_data, rd_data, d;
	logic [23:0] spi_bytes;
	logic [2:0]  outs;
	logic [31:0] seed;
	int          failures, total_checks, fall_idx;
	// Open-drain wires: low if anybody pulls, pull-up otherwise
	assign l3 = !oe3;
	assign l4 = !(oe4 || sd_pull);
	assign l5 = !oe5;
	gpio_bridge #(.WDOG_CYCLES(WD)) uut (.clk(clk), .nrst(nrst), .buffer_write_command(wr_cmd),
		.write_data(wr_data), .write_pec_ok(pec_ok), .start_transfer_command(st_cmd),
		.host_tick(tick), .host_chip_select_rise(cs_rise), .buffer_read_command(rd_cmd),
		.read_data(rd_data), .read_valid(rd_valid), .busy(busy), .gpio3_in(l3),
		.gpio3_out(outs[2]), .gpio3_oe(oe3), .gpio4_in(l4), .gpio4_out(outs[1]),
		.gpio4_oe(oe4), .gpio5_in(l5), .gpio5_out(outs[0]), .gpio5_oe(oe5));
	slave_model slave (.spi_mode(spi_mode), .ack_en(ack_en), .spi_bytes(spi_bytes),
		.cs_line(l3), .sd_line(l4), .sck_line(l5), .sd_pull(sd_pull));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] b(input logic [7:0] m);
		logic [31:0] r;
		r = rnd();
		return r[7:0] & m;
	endfunction : b
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : test_done
	task automatic wr(input logic [47:0] v, input logic ok);
		@(negedge clk);
		wr_cmd = 1'b1;
		wr_data = v;
		pec_ok = ok;
		@(negedge clk);
		wr_cmd = 1'b0;
	endtask : wr
	task automatic rd(input logic [47:0] exp);
		@(negedge clk);
		rd_cmd = 1'b1;
		@(negedge clk);
		rd_cmd = 1'b0;
		chk("read_valid", 48'h1, {47'h0, rd_valid});
		chk("read_data", exp, rd_data);
	endtask : rd
	// One start-transfer with 72 ticks, then the model's buffer is compared
	task automatic run(input logic [47:0] img, input logic spi, input logic ack,
		input logic [2:0] oe_exp);
		logic [47:0] exp;
		logic [15:0] w;
		logic [7:0]  rx;
		logic        sda_hi;
		sda_hi = 1'b1;
		exp = img;
		wr(img, 1'b1);
		spi_mode = spi;
		ack_en = ack;
		@(negedge clk);
		st_cmd = 1'b1;
		@(negedge clk);
		st_cmd = 1'b0;
		chk("busy", 48'h1, {47'h0, busy});
		for (int k = 0; k < 72; k++) begin
			tick = 1'b1;
			// A write while busy must be ignored
			if (k == 10) begin
				wr_cmd = 1'b1;
				wr_data = {16'h5a5a, rnd()};
			end
			@(negedge clk);
			tick = 1'b0;
			wr_cmd = 1'b0;
			@(negedge clk);
		end
		for (int s = 0; s < 3; s++) begin
			w = img[47 - 16 * s -: 16];
			rx = w[11:4];
			if (spi) begin
				// Shared open-drain data line: the byte seen is master AND slave
				if (w[15:12] == 4'ha || (w[15:12] == 4'h8 && cs_hi)) begin
					rx = rx & spi_bytes[23 - 8 * (fall_idx % 3) -: 8];
					fall_idx++;
				end
				cs_hi = (w[15:12] == 4'h9 || w[15:12] == 4'hf || w[3:0] == 4'h9);
				w = {4'h7, rx, 4'hf};
			end else if (w[15:12] != 4'h1 && w[15:12] != 4'h7) begin
				if (w[15:12] == 4'h0 && sda_hi) w[15:12] = 4'h7;
				if (w[3:0] == 4'h8) w[3:0] = ack ? 4'h7 : 4'hf;
				if (w[3:0] == 4'h9) w[3:0] = ack ? 4'h1 : 4'h9;
				sda_hi = (img[35 - 16 * s -: 4] != 4'h0);
			end
			exp[47 - 16 * s -: 16] = w;
		end
		chk("busy", 48'h0, {47'h0, busy});
		chk("pin enables", {45'h0, oe_exp}, {45'h0, oe3, oe4, oe5});
		chk("pin outputs", 48'h0, {45'h0, outs});
		rd(exp);
	endtask : run
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("MISMATCH run time expected finish seen timeout");
		test_done();
	end
	initial begin
		{nrst, wr_cmd, pec_ok, st_cmd, tick, cs_rise, rd_cmd, spi_mode, ack_en} = 9'h0;
		wr_data = 48'h0;
		seed = 32'hbc01;
		failures = 0;
		total_checks = 0;
		fall_idx = 0;
		cs_hi = 1'b1;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		spi_bytes = 24'(rnd());
		rd(48'hffff_ffff_ffff);
		d = {rnd(), seed[15:0]};
		wr(d, 1'b1);
		rd(d);
		wr(~d, 1'b0);
		rd(d);
		@(negedge clk);
		cs_rise = 1'b1;
		@(negedge clk);
		cs_rise = 1'b0;
		rd(48'hffff_ffff_ffff);
		// Host codes select low first; the first run raises it after the last byte, the second at its no-transmit slot, the third leaves it low
		run({4'ha, b(8'hff), 8'h0a, b(8'hff), 8'h0a, b(8'hff), 4'h9}, 1'b1, 1'b0, 3'b000);
		run({4'h8, b(8'hff), 8'h0f, b(8'hff), 8'h09, b(8'hff), 4'h9}, 1'b1, 1'b0, 3'b000);
		run({4'h8, b(8'hff), 8'h08, b(8'hff), 8'h08, b(8'hff), 4'h0}, 1'b1, 1'b0, 3'b100);
		repeat (WD + 10) @(negedge clk);
		chk("select after watchdog", 48'h0, {47'h0, oe3});
		// Slave ack (first run only) lands on the ninth clock, after the data byte has gone out
		run({4'h6, b(8'hfe), 8'h80, b(8'hfe), 8'h91, b(8'hfe), 4'h0}, 1'b0, 1'b1, 3'b000);
		run({4'h6, b(8'hfe), 8'h80, b(8'hfe), 8'h97, b(8'hfe), 4'h0}, 1'b0, 1'b0, 3'b000);
		test_done();
	end
endmodule : gpio_bridge_tb_top
`default_nettype wire
